// *** acps_top.v ***
// active clamp pwm sequencer: oscillator, soft-start/stop, faults, ahb regs
`timescale 1ns/1ps
`include "acps_consts.vh"

module acps_top #(
  parameter CW = 16
) (
  // clock and reset
  input  wire        MCLK,
  input  wire        RST,
  // ahb-lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  // comparator and sync pins, asynchronous to mclk
  input  wire        SYNC_IN,
  input  wire        BIAS_LOCKOUT,
  input  wire        LINE_LOW_FAULT,
  input  wire        LINE_HIGH_FAULT,
  input  wire        FEEDBACK_LEVEL_LOW,
  input  wire        CURRENT_TRIP,
  // gate drives and interrupt
  output reg         MAIN_OUT,
  output reg         CLAMP_OUT,
  output reg         IRQ
);

  localparam ST_OFF  = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_STOP = 2'b10;
  localparam ST_OV   = 2'b11;
  localparam NPIN    = 6;

  // two-flop synchronisers for every pin input
  reg  [NPIN-1:0] meta_q;
  reg  [NPIN-1:0] pin_q;
  wire [NPIN-1:0] pin_raw;
  assign pin_raw = {CURRENT_TRIP, FEEDBACK_LEVEL_LOW, LINE_HIGH_FAULT,
                    LINE_LOW_FAULT, BIAS_LOCKOUT, SYNC_IN};
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      always @(posedge MCLK) begin
        if (RST) begin
          meta_q[g] <= 1'b0;
          pin_q[g]  <= 1'b0;
        end else begin
          meta_q[g] <= pin_raw[g];
          pin_q[g]  <= meta_q[g];
        end
      end
    end
  endgenerate

  wire sync_lvl  = pin_q[0];
  wire bias_lock = pin_q[1];
  wire line_low  = pin_q[2];
  wire line_high = pin_q[3];
  wire fb_low    = pin_q[4];
  wire cur_trip  = pin_q[5];

  // sync edge detect on the synchronised level only
  reg  sync_d1_q;
  wire sync_rise = sync_lvl & ~sync_d1_q;
  always @(posedge MCLK) begin
    if (RST)
      sync_d1_q <= 1'b0;
    else
      sync_d1_q <= sync_lvl;
  end

  // software registers
  reg          en_q;
  reg [CW-1:0] charge_q;
  reg [CW-1:0] disch_q;
  reg [15:0]   ssdiv_q;
  reg [3:0]    irq_stat_q;
  reg [3:0]    irq_mask_q;

  // ahb address phase capture
  reg        dp_wr_q;
  reg [7:0]  dp_addr_q;
  wire       ap_valid = HSEL & HTRANS[1] & HREADY;
  wire       wr_now   = dp_wr_q;

  // soft-start and state
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [15:0] ss_q;
  reg [15:0] ss_div_cnt_q;
  wire       ss_tick = (ss_div_cnt_q >= ssdiv_q);

  // oscillator ramp
  reg          charging_q;
  reg          flat_q;
  reg [CW-1:0] ramp_cnt_q;
  reg          cyc_pulsed_q;
  reg          main_d;
  reg          clamp_d;

  // events for the interrupt status
  reg  [3:0] ev;

  // state machine: line low soft-stops, line high hard-stops
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (line_high)
          state_d = ST_OV;
        else if (en_q && !bias_lock && !line_low &&
                 ss_q <= `ACPS_SS_RESTART_MV)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (line_high)
          state_d = ST_OV;
        else if (line_low)
          state_d = ST_STOP;
        else if (!en_q || bias_lock)
          state_d = ST_OFF;
      end
      ST_STOP: begin
        if (line_high)
          state_d = ST_OV;
        else if (ss_q <= `ACPS_SS_RESTART_MV)
          state_d = ST_OFF;
      end
      ST_OV: begin
        if (!line_high && ss_q <= `ACPS_SS_RESTART_MV)
          state_d = ST_OFF;
      end
      default: state_d = ST_OFF;
    endcase
  end

  // state register and event strobes
  always @(posedge MCLK) begin
    if (RST)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  always @* begin
    ev = 4'h0;
    ev[`ACPS_EV_OV_BIT]      = (state_d == ST_OV) && (state_q != ST_OV);
    ev[`ACPS_EV_UV_BIT]      = (state_d == ST_STOP) && (state_q != ST_STOP);
    ev[`ACPS_EV_RESTART_BIT] = (state_d == ST_RUN) && (state_q != ST_RUN);
    ev[`ACPS_EV_SYNC_BIT]    = sync_rise;
  end

  // soft-start level: ramps up in run, down at the same rate everywhere else
  always @(posedge MCLK) begin
    if (RST) begin
      ss_q         <= 16'h0000;
      ss_div_cnt_q <= 16'h0000;
    end else begin
      if (ss_tick)
        ss_div_cnt_q <= 16'h0000;
      else
        ss_div_cnt_q <= ss_div_cnt_q + 16'h0001;
      if (ss_tick) begin
        if (state_q == ST_RUN) begin
          if (ss_q < `ACPS_SS_MAX_MV)
            ss_q <= ss_q + 16'h0001;
        end else if (ss_q != 16'h0000) begin
          ss_q <= ss_q - 16'h0001;
        end
      end
    end
  end

  // pulses allowed only in run or soft-stop, with no line high, bias lockout or feedback low, and ss at or above the stop level
  // a line high fault gates off at once, without waiting for the state
  wire pulse_ok = ((state_q == ST_RUN) || (state_q == ST_STOP)) &&
                  !line_high &&
                  !bias_lock && !fb_low &&
                  (ss_q >= `ACPS_SS_STOP_MV);

  // ramp counter; a sync edge jumps straight into discharge
  always @(posedge MCLK) begin
    if (RST) begin
      charging_q <= 1'b1;
      flat_q     <= 1'b0;
      ramp_cnt_q <= {CW{1'b0}};
    end else if (charging_q) begin
      if (sync_rise || ramp_cnt_q + 1'b1 >= charge_q) begin
        charging_q <= 1'b0;
        ramp_cnt_q <= {CW{1'b0}};
      end else begin
        ramp_cnt_q <= ramp_cnt_q + 1'b1;
      end
    end else if (ramp_cnt_q + 1'b1 >= disch_q) begin
      // valley reached: a sync level still high holds the ramp flat
      if (sync_lvl) begin
        flat_q <= 1'b1;
      end else begin
        flat_q     <= 1'b0;
        charging_q <= 1'b1;
        ramp_cnt_q <= {CW{1'b0}};
      end
    end else begin
      ramp_cnt_q <= ramp_cnt_q + 1'b1;
    end
  end

  wire charge_start = !charging_q && !sync_lvl &&
                      (ramp_cnt_q + 1'b1 >= disch_q);
  // last charge count: main must already be low when discharge begins
  wire charge_end = charging_q && (ramp_cnt_q + 1'b1 >= charge_q);

  // gate decisions; main only within charge, clamp only after a main pulse
  always @* begin
    main_d  = MAIN_OUT;
    clamp_d = 1'b0;
    if (!pulse_ok || !charging_q || cur_trip) begin
      main_d = 1'b0;
    end
    if (charge_start) begin
      main_d = 1'b0;
    end else if (charging_q && ramp_cnt_q == {CW{1'b0}} && !MAIN_OUT &&
                 !cyc_pulsed_q) begin
      main_d = pulse_ok && !cur_trip;
    end
    // last charge count or a sync edge: main is low before discharge starts
    if (sync_rise || charge_end)
      main_d = 1'b0;
    clamp_d = cyc_pulsed_q && !main_d && !MAIN_OUT && !flat_q &&
              !charging_q && pulse_ok;
  end

  // per-cycle memory of whether the main pulse fired
  always @(posedge MCLK) begin
    if (RST)
      cyc_pulsed_q <= 1'b0;
    else if (charge_start)
      cyc_pulsed_q <= 1'b0;
    else if (main_d)
      cyc_pulsed_q <= 1'b1;
  end

  // gate outputs straight from flops
  always @(posedge MCLK) begin
    if (RST) begin
      MAIN_OUT  <= 1'b0;
      CLAMP_OUT <= 1'b0;
    end else begin
      MAIN_OUT  <= main_d;
      CLAMP_OUT <= clamp_d & ~main_d;
    end
  end

  // ahb data phase bookkeeping; zero wait states, always okay
  always @(posedge MCLK) begin
    if (RST) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (HREADY) begin
        dp_wr_q   <= ap_valid & HWRITE;
        dp_addr_q <= HADDR[7:0];
      end
    end
  end

  // register writes; hardware set wins over write-one-to-clear
  always @(posedge MCLK) begin
    if (RST) begin
      en_q       <= `ACPS_RST_CTRL;
      charge_q   <= `ACPS_RST_CHARGE;
      disch_q    <= `ACPS_RST_DISCH;
      ssdiv_q    <= `ACPS_RST_SSDIV;
      irq_mask_q <= `ACPS_RST_MASK;
      irq_stat_q <= 4'h0;
    end else begin
      if (wr_now) begin
        case (dp_addr_q)
          `ACPS_OFF_CTRL:     en_q       <= HWDATA[`ACPS_CTRL_EN_BIT];
          `ACPS_OFF_CHARGE:   charge_q   <= HWDATA[CW-1:0];
          `ACPS_OFF_DISCH:    disch_q    <= HWDATA[CW-1:0];
          `ACPS_OFF_SSDIV:    ssdiv_q    <= HWDATA[15:0];
          `ACPS_OFF_IRQ_MASK: irq_mask_q <= HWDATA[3:0];
          default: ;
        endcase
      end
      if (wr_now && dp_addr_q == `ACPS_OFF_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~HWDATA[3:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
    end
  end

  // read data registered in the address phase, valid in the data phase
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (HADDR[7:0])
      `ACPS_OFF_CTRL:     rd_d[`ACPS_CTRL_EN_BIT] = en_q;
      `ACPS_OFF_CHARGE:   rd_d[CW-1:0] = charge_q;
      `ACPS_OFF_DISCH:    rd_d[CW-1:0] = disch_q;
      `ACPS_OFF_SSDIV:    rd_d[15:0] = ssdiv_q;
      `ACPS_OFF_STATUS: begin
        rd_d[`ACPS_ST_STATE_LSB+1:`ACPS_ST_STATE_LSB] = state_q;
        rd_d[`ACPS_ST_MAIN_BIT]  = MAIN_OUT;
        rd_d[`ACPS_ST_CLAMP_BIT] = CLAMP_OUT;
        rd_d[`ACPS_ST_SYNC_BIT]  = sync_lvl;
        rd_d[`ACPS_ST_SS_LSB+15:`ACPS_ST_SS_LSB] = ss_q;
      end
      `ACPS_OFF_IRQ_STAT: rd_d[3:0] = irq_stat_q;
      `ACPS_OFF_IRQ_MASK: rd_d[3:0] = irq_mask_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read data and interrupt level, both from flops
  always @(posedge MCLK) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
      IRQ    <= 1'b0;
    end else begin
      if (ap_valid && !HWRITE)
        HRDATA <= rd_d;
      IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end

  // sync pins tied between parts give the same edge, duty stays local
  // each part keeps its own charge_q, so its duty limit is its own

endmodule

// *** acps_consts.vh ***
// constants for the active clamp pwm sequencer: offsets, fields, resets, levels
`ifndef ACPS_CONSTS_VH
`define ACPS_CONSTS_VH

// register byte offsets on the ahb-lite bus
`define ACPS_OFF_CTRL      8'h00
`define ACPS_OFF_CHARGE    8'h04
`define ACPS_OFF_DISCH     8'h08
`define ACPS_OFF_SSDIV     8'h0C
`define ACPS_OFF_STATUS    8'h10
`define ACPS_OFF_IRQ_STAT  8'h14
`define ACPS_OFF_IRQ_MASK  8'h18

// field positions
`define ACPS_CTRL_EN_BIT   0
`define ACPS_ST_STATE_LSB  0
`define ACPS_ST_MAIN_BIT   2
`define ACPS_ST_CLAMP_BIT  3
`define ACPS_ST_SYNC_BIT   4
`define ACPS_ST_SS_LSB     16
`define ACPS_EV_OV_BIT     0
`define ACPS_EV_UV_BIT     1
`define ACPS_EV_RESTART_BIT 2
`define ACPS_EV_SYNC_BIT   3

// reset values
`define ACPS_RST_CTRL      1'h0
`define ACPS_RST_CHARGE    16'h0050
`define ACPS_RST_DISCH     16'h0014
`define ACPS_RST_SSDIV     16'h0005
`define ACPS_RST_MASK      4'h0

// soft-start level in millivolts
`define ACPS_SS_STOP_MV    16'h09C4
`define ACPS_SS_RESTART_MV 16'h01F4
`define ACPS_SS_MAX_MV     16'h1388

`endif

// *** acps_chk_assertions.sv ***
// checker: gate sequencing assertions on the top ports
`timescale 1ns/1ps
`include "acps_consts.vh"
module acps_chk (
  // clock, reset and bus
  input wire        MCLK,
  input wire        RST,
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [31:0] HWDATA,
  input wire        HREADY,
  // pins
  input wire        SYNC_IN,
  input wire        BIAS_LOCKOUT,
  input wire        LINE_HIGH_FAULT,
  input wire        FEEDBACK_LEVEL_LOW,
  input wire        MAIN_OUT,
  input wire        CLAMP_OUT
);
  reg        chg_wr_q;
  reg [15:0] chg_q;
  reg [15:0] on_q;
  reg [7:0]  hi_q;
  reg        fired_q;
  // shadow of the charge count, run lengths of main high and sync high
  always @(posedge MCLK) begin
    if (RST) begin
      chg_wr_q <= 1'b0;
      chg_q    <= `ACPS_RST_CHARGE;
      on_q     <= 16'h0000;
      hi_q     <= 8'h00;
      fired_q  <= 1'b0;
    end else begin
      // a main pulse seen since the last clamp pulse; a trip may cut main
      // long before the clamp may rise, so no fixed distance is assumed
      fired_q <= MAIN_OUT | (fired_q & ~CLAMP_OUT);
      chg_wr_q <= HSEL & HTRANS[1] & HREADY & HWRITE
                  & (HADDR[7:0] == `ACPS_OFF_CHARGE);
      if (chg_wr_q)
        chg_q <= HWDATA[15:0];
      on_q <= MAIN_OUT ? on_q + 16'h0001 : 16'h0000;
      hi_q <= !SYNC_IN ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
    end
  end
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (RST);
  // inputs pass two flops, so five samples cover the latency
  sequence s_ov; LINE_HIGH_FAULT [*5]; endsequence
  sequence s_bias; BIAS_LOCKOUT [*5]; endsequence
  sequence s_fb; FEEDBACK_LEVEL_LOW [*5]; endsequence
  sequence s_sync_rise; !SYNC_IN ##1 SYNC_IN [*5]; endsequence
  a_gates_apart: assert property (!(MAIN_OUT && CLAMP_OUT))
    else $error("main and clamp high together");
  a_ov_gates_off: assert property (s_ov |-> !MAIN_OUT && !CLAMP_OUT)
    else $error("gate on during line high fault");
  a_bias_gates_off: assert property (s_bias |-> !MAIN_OUT && !CLAMP_OUT)
    else $error("gate on during bias lockout");
  a_fb_main_off: assert property (s_fb |-> !MAIN_OUT)
    else $error("main on with feedback low");
  a_clamp_needs_main: assert property ($rose(CLAMP_OUT) |-> fired_q)
    else $error("clamp pulse without main pulse");
  a_main_rest: assert property ($fell(MAIN_OUT) |-> !MAIN_OUT [*8])
    else $error("main back on during discharge");
  a_main_on_limit: assert property (on_q <= chg_q)
    else $error("main on longer than charge count");
  a_sync_high_off: assert property (hi_q > 8'h28 |->
    !MAIN_OUT && !CLAMP_OUT)
    else $error("gate on with sync held high");
  a_sync_ends_charge: assert property (s_sync_rise |-> !MAIN_OUT)
    else $error("sync edge did not end charge");
endmodule
bind acps_top acps_chk i_chk (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .SYNC_IN(SYNC_IN), .BIAS_LOCKOUT(BIAS_LOCKOUT),
  .LINE_HIGH_FAULT(LINE_HIGH_FAULT), .FEEDBACK_LEVEL_LOW(FEEDBACK_LEVEL_LOW),
  .MAIN_OUT(MAIN_OUT), .CLAMP_OUT(CLAMP_OUT));

// *** acps_sync_src.sv ***
// external sync source model driving the sync pin
`timescale 1ns/1ps
module acps_sync_src (
  // control
  input  wire run,
  input  wire hold,
  // sync pin
  output reg  sync
);
  // 200 ns pulse every 4 link periods of 320 ns, phase offset from mclk
  initial begin
    sync = 1'b0;
    #13;
    forever begin
      sync = hold | run;
      if (hold || !run)
        #320;
      else begin
        #200;
        sync = 1'b0;
        #1080;
      end
    end
  end
endmodule

// *** test_acps_top.sv ***
// self-checking bench of the active clamp pwm sequencer
`timescale 1ns/1ps
`include "acps_consts.vh"
module test_acps_top;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         bias = 1'b0;
  reg         line_lo = 1'b0;
  reg         line_hi = 1'b0;
  reg         fb_lo = 1'b0;
  reg         trip = 1'b0;
  reg         s_run = 1'b0;
  reg         s_hold = 1'b0;
  reg         main_d = 1'b0;
  reg         clamp_p = 1'b0;
  wire        sync, main, clamp, irq, hrdy, hresp;
  wire [31:0] hrdata;
  reg  [31:0] rd;
  reg  [15:0] chg, dis, a16;
  reg  [7:0]  a;
  integer     error_cnt = 0, n_checks = 0, cyc = 0;
  integer     n_rise = 0, per = 0, last = 0, n0, n_clamp = 0, c0;

  acps_top i_acps_top (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
    .SYNC_IN(sync), .BIAS_LOCKOUT(bias), .LINE_LOW_FAULT(line_lo),
    .LINE_HIGH_FAULT(line_hi), .FEEDBACK_LEVEL_LOW(fb_lo),
    .CURRENT_TRIP(trip), .MAIN_OUT(main), .CLAMP_OUT(clamp), .IRQ(irq));
  acps_sync_src i_acps_sync_src (.run(s_run), .hold(s_hold), .sync(sync));

  always #20 mclk = ~mclk;
  // cycle count, hang limit, main rising edges and their spacing
  always @(posedge mclk) begin
    cyc = cyc + 1;
    main_d <= main;
    clamp_p <= clamp;
    if (clamp === 1'b1 && clamp_p === 1'b0)
      n_clamp = n_clamp + 1;
    if (main === 1'b1 && main_d === 1'b0) begin
      n_rise = n_rise + 1;
      per = cyc - last;
      last = cyc;
    end
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one single word transfer, read data land in rd
  task ahb(input w, input [7:0] ad, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0, ad};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge mclk);
      while (hrdy !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hrdy !== 1'b1) @(posedge mclk);
      rd = hrdata;
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task st;
    ahb(1'b0, `ACPS_OFF_STATUS, 32'h0);
  endtask
  // poll the soft-start level until it is at or below lim
  task ss_to(input [15:0] lim);
    begin
      st;
      while (rd[31:16] > lim) begin
        idle(50);
        st;
      end
    end
  endtask
  function [31:0] rst_val(input [7:0] ad);
    case (ad)
      `ACPS_OFF_CHARGE: rst_val = {16'h0, `ACPS_RST_CHARGE};
      `ACPS_OFF_DISCH:  rst_val = {16'h0, `ACPS_RST_DISCH};
      `ACPS_OFF_SSDIV:  rst_val = {16'h0, `ACPS_RST_SSDIV};
      default:          rst_val = 32'h0;
    endcase
  endfunction

  initial begin
    rd = $urandom(32'h76aec1cf);
    idle(20);
    rst <= 1'b0;
    idle(1);
    // reset values, unmapped word at 0x1C included
    for (a = 8'h00; a < 8'h20; a = a + 8'h04) begin
      ahb(1'b0, a, 32'h0);
      chk("reset", rd, rst_val(a));
    end
    chk("okay", hresp, 1'b0);
    // charge kept long enough that the 32-cycle sync always cuts it
    chg = 16'h0018 + {12'h0, 4'($urandom)};
    dis = 16'h000A + {13'h0, 3'($urandom)};
    ahb(1'b1, `ACPS_OFF_CHARGE, {16'h0, chg});
    ahb(1'b1, `ACPS_OFF_DISCH, {16'h0, dis});
    ahb(1'b1, `ACPS_OFF_SSDIV, 32'h0);
    ahb(1'b1, `ACPS_OFF_IRQ_MASK, 32'hF);
    ahb(1'b1, `ACPS_OFF_CTRL, 32'h1);
    idle(2700);
    // random current trips shorten pulses but not the period
    repeat (300) begin
      @(posedge mclk);
      trip <= ($urandom % 8) == 0;
    end
    trip <= 1'b0;
    // a trip at the start of charge skips a pulse: measure clean periods
    idle(150);
    chk("free per", per, chg + dis);
    chk("irq on", irq, 1'b1);
    ahb(1'b0, `ACPS_OFF_IRQ_STAT, 32'h0);
    chk("restart ev", rd[2], 1'b1);
    ahb(1'b1, `ACPS_OFF_IRQ_STAT, 32'hF);
    ahb(1'b1, `ACPS_OFF_IRQ_MASK, 32'h0);
    idle(2);
    chk("irq clear", irq, 1'b0);
    // synchronised run, then sync held high
    s_run <= 1'b1;
    idle(400);
    chk("sync per", per, 32);
    ahb(1'b0, `ACPS_OFF_IRQ_STAT, 32'h0);
    chk("sync ev", rd[3], 1'b1);
    chk("masked", irq, 1'b0);
    ahb(1'b1, `ACPS_OFF_IRQ_MASK, 32'h8);
    idle(2);
    chk("unmasked", irq, 1'b1);
    s_hold <= 1'b1;
    idle(60);
    n0 = n_rise;
    idle(200);
    chk("sync held", n_rise - n0, 0);
    s_hold <= 1'b0;
    s_run <= 1'b0;
    fb_lo <= 1'b1;
    idle(60);
    n0 = n_rise;
    c0 = n_clamp;
    idle(200);
    chk("fb skip", n_rise - n0, 0);
    chk("fb clamp", n_clamp - c0, 0);
    fb_lo <= 1'b0;
    // line high: gates off at once, slow ramp down, restart after clear
    line_hi <= 1'b1;
    idle(5);
    chk("ov gates", {main, clamp}, 2'b00);
    st;
    chk("ov state", rd[1:0], 2'h3);
    a16 = rd[31:16];
    idle(100);
    st;
    chk("ov ramp", rd[31:16] < a16, 1'b1);
    n0 = n_rise;
    ss_to(`ACPS_SS_RESTART_MV);
    idle(200);
    st;
    chk("ov held", rd[1:0], 2'h3);
    chk("ov quiet", n_rise - n0, 0);
    line_hi <= 1'b0;
    idle(3000);
    chk("ov restart", n_rise > n0, 1'b1);
    // line low: soft-stop keeps switching, stops below 2.5 V
    line_lo <= 1'b1;
    n0 = n_rise;
    c0 = n_clamp;
    idle(100);
    st;
    chk("ll state", rd[1:0], 2'h2);
    chk("ll switch", n_rise > n0, 1'b1);
    chk("ll clamp", n_clamp > c0, 1'b1);
    ahb(1'b0, `ACPS_OFF_IRQ_STAT, 32'h0);
    chk("ev flags", rd[3:0], 4'hF);
    ss_to(`ACPS_SS_STOP_MV - 16'h0064);
    idle(10);
    n0 = n_rise;
    idle(200);
    chk("ll stop", n_rise - n0, 0);
    line_lo <= 1'b0;
    // restart follows at once at the floor, so poll a window just above it
    ss_to(`ACPS_SS_RESTART_MV + 16'h0064);
    idle(3000);
    chk("ll restart", n_rise > n0, 1'b1);
    bias <= 1'b1;
    idle(10);
    st;
    chk("bias off", rd[3:0], 4'h0);
    complete_run;
  end
endmodule
